// ===== selftest_pkg.sv
`default_nettype none
package selftest_pkg;
  // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
  localparam logic [7:0] IDX_SELFTEST_CONTROL = 8'h24;
  localparam logic [7:0] IDX_SELFTEST_ERRORS  = 8'h25;
  localparam logic [7:0] IDX_CLOCK_HIGH_WIDTH = 8'h26;
  localparam logic [7:0] IDX_CLOCK_LOW_WIDTH  = 8'h27;
  localparam logic [7:0] IDX_IRQ_STATUS       = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK         = 8'h31;

  localparam logic [7:0] RST_SELFTEST_CONTROL = 8'h08;
  localparam logic [7:0] RST_CLOCK_HIGH_WIDTH = 8'h83;
  localparam logic [7:0] RST_CLOCK_LOW_WIDTH  = 8'h84;
  localparam logic [7:0] RST_ERRORS           = 8'h00;

  // selftest control field positions
  localparam int CTL_EN_BIT     = 0;
  localparam int CTL_CSRC_LO    = 1;
  localparam int CTL_PIN_BIT    = 3;
  localparam int CTL_FREQ_LO    = 4;

  // oscillator frequency select codes and their nominal rates
  localparam logic [1:0] FREQ_50MHZ = 2'h0;
  localparam logic [1:0] FREQ_25MHZ = 2'h1;
  localparam logic [1:0] FREQ_10MHZ = 2'h2;

  // clock source codes; any code other than 00 means internal
  localparam logic [1:0] CSRC_EXTERNAL = 2'h0;
  localparam logic [1:0] CSRC_INTERNAL = 2'h1;

  // remote serializer register written on self-test start
  localparam logic [7:0] REMOTE_CLOCK_SRC_OFFSET = 8'h14;

  // one width unit, in ns, and in cycles of the 100 MHz aclk
  localparam int UNIT_NS     = 50;
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_CYCLES = UNIT_NS / CLK_PERIOD_NS;

  // interrupt status bits
  localparam int IRQ_ERROR_BIT   = 0;
  localparam int IRQ_WRAP_BIT    = 1;
  localparam int IRQ_SCL_BIT     = 2;
  localparam int IRQ_W           = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] freq_sel;
    logic       pin_config;
    logic [1:0] clock_source;
    logic       enable;
  } selftest_ctrl_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] offset;
    logic [1:0] data;
  } remote_write_t;
endpackage
`default_nettype wire

// ===== scl_pulse_timer.sv
`default_nettype none
// free-running scl generator: high for high_width units, low for low_width units
module scl_pulse_timer
  import selftest_pkg::*;
#(
  parameter int UNIT_CYC = UNIT_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [7:0] high_width,
  input  wire logic [7:0] low_width,
  output logic            scl_level,
  output logic            low_phase_done
);
  logic [7:0] unit_cnt_reg;
  logic [7:0] width_cnt_reg;
  logic       unit_tick;

  // one-cycle enable every 50 ns
  assign unit_tick = (unit_cnt_reg == 8'(UNIT_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || !run || unit_tick) begin
      unit_cnt_reg <= 8'h00;
    end else begin
      unit_cnt_reg <= unit_cnt_reg + 8'h01;
    end
  end

  // a zero width still gives one unit so the clock keeps moving
  always_ff @(posedge aclk) begin
    low_phase_done <= 1'b0;
    if (!aresetn || !run) begin
      scl_level     <= 1'b1;
      width_cnt_reg <= 8'h00;
    end else if (unit_tick) begin
      if (width_cnt_reg + 8'h01 >= (scl_level ? high_width : low_width)) begin
        width_cnt_reg  <= 8'h00;
        low_phase_done <= !scl_level;
        scl_level      <= !scl_level;
      end else begin
        width_cnt_reg <= width_cnt_reg + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== selftest_regs.sv
`default_nettype none
// Behaviour
// - freq field picks 50/25/10 MHz oscillator rate
// - config source: pin if set, else register
// - clock source 00 external, others internal
// - on enable, copy clock source to remote 0x14
// - self-test runs while enable bit is one
// - read-only eight-bit error tally, resets zero
// - high width sets master scl high time
// - high width resets to 83h
// - low width sets master scl low time
// - slave uses low width as sda setup
// - low width resets to 84h
module selftest_regs
  import selftest_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        auto_clock_en,
  input  wire logic        selftest_pin_en,
  input  wire logic [1:0]  selftest_pin_csrc,
  input  wire logic        selftest_error,
  input  wire logic        slave_setup_start,
  output logic             selftest_active,
  output logic             internal_pclk_sel,
  output logic [1:0]       receive_osc_freq_select,
  output logic             osc_freq_valid,
  output remote_write_t    remote_write,
  output logic             scl_out,
  output logic             scl_oe,
  output logic             slave_scl_release,
  output logic             irq
);
  import selftest_pkg::*;

  selftest_ctrl_t ctrl_reg;
  logic [1:0]     ctrl_rsvd_reg;
  logic [7:0]     errors_reg;
  logic [7:0]     high_width_reg;
  logic [7:0]     low_width_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [7:0]     setup_cnt_reg;
  logic           setup_busy_reg;
  logic [7:0]     setup_div_reg;
  logic           active_prev_reg;

  logic           aw_held_reg;
  logic           w_held_reg;
  logic [7:0]     aw_idx_reg;
  logic [31:0]    w_data_reg;
  logic [3:0]     w_strb_reg;
  logic           wr_fire;
  logic           run_en;
  logic [1:0]     csrc;
  logic           scl_level;
  logic [7:0]     rd_idx;
  logic [7:0]     rd_byte;
  logic           rd_hit;
  logic [IRQ_W-1:0] irq_events;

  // pin or register decides self-test enable and clock source
  assign run_en = ctrl_reg.pin_config ? selftest_pin_en : ctrl_reg.enable;
  assign csrc   = ctrl_reg.pin_config ? selftest_pin_csrc : ctrl_reg.clock_source;

  // write address and data are taken in either order, then one response
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held_reg   <= 1'b0;
      aw_idx_reg    <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_idx_reg    <= s_axi_awaddr[9:2];
    end else if (wr_fire) begin
      aw_held_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response; unmapped indices answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      case (aw_idx_reg)
        IDX_SELFTEST_CONTROL, IDX_SELFTEST_ERRORS, IDX_CLOCK_HIGH_WIDTH,
        IDX_CLOCK_LOW_WIDTH, IDX_IRQ_STATUS, IDX_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers; only byte lane 0 carries the field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ctrl_rsvd_reg, ctrl_reg} <= RST_SELFTEST_CONTROL;
      high_width_reg <= RST_CLOCK_HIGH_WIDTH;
      low_width_reg  <= RST_CLOCK_LOW_WIDTH;
      irq_mask_reg   <= '0;
    end else if (wr_fire && w_strb_reg[0]) begin
      case (aw_idx_reg)
        IDX_SELFTEST_CONTROL: {ctrl_rsvd_reg, ctrl_reg} <= w_data_reg[7:0];
        IDX_CLOCK_HIGH_WIDTH: high_width_reg <= w_data_reg[7:0];
        IDX_CLOCK_LOW_WIDTH:  low_width_reg  <= w_data_reg[7:0];
        IDX_IRQ_MASK:         irq_mask_reg   <= w_data_reg[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // error tally counts while running, saturating; cleared when a run starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      errors_reg <= RST_ERRORS;
    end else if (run_en && !active_prev_reg) begin
      errors_reg <= RST_ERRORS;
    end else if (run_en && selftest_error && errors_reg != 8'hFF) begin
      errors_reg <= errors_reg + 8'h01;
    end
  end

  // run state and copy of clock source to the remote on each start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_prev_reg   <= 1'b0;
      selftest_active   <= 1'b0;
      internal_pclk_sel <= 1'b0;
      remote_write      <= '0;
    end else begin
      active_prev_reg   <= run_en;
      selftest_active   <= run_en;
      internal_pclk_sel <= (csrc != CSRC_EXTERNAL);
      remote_write.valid  <= run_en && !active_prev_reg;
      remote_write.offset <= REMOTE_CLOCK_SRC_OFFSET;
      remote_write.data   <= csrc;
    end
  end

  // oscillator rate select only matters under auto clock; 11 is not a rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_osc_freq_select <= FREQ_50MHZ;
      osc_freq_valid          <= 1'b0;
    end else begin
      receive_osc_freq_select <= ctrl_reg.freq_sel;
      osc_freq_valid <= auto_clock_en && (ctrl_reg.freq_sel == FREQ_50MHZ ||
        ctrl_reg.freq_sel == FREQ_25MHZ || ctrl_reg.freq_sel == FREQ_10MHZ);
    end
  end

  // master scl timing; runs always, the master enables the pin driver
  scl_pulse_timer u_scl (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .run            (1'b1),
    .high_width     (high_width_reg),
    .low_width      (low_width_reg),
    .scl_level      (scl_level),
    .low_phase_done ()
  );

  // open drain: drive low only, release while high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe  <= !scl_level;
    end
  end

  // slave sda setup: scl stays stretched for low width units of 50 ns after the data is
  // presented; its own divider, so the interval does not depend on the master phase
  always_ff @(posedge aclk) begin
    slave_scl_release <= 1'b0;
    if (!aresetn) begin
      setup_busy_reg <= 1'b0;
      setup_cnt_reg  <= 8'h00;
      setup_div_reg  <= 8'h00;
    end else if (slave_setup_start && !setup_busy_reg) begin
      setup_busy_reg <= 1'b1;
      setup_cnt_reg  <= 8'h00;
      setup_div_reg  <= 8'h00;
    end else if (setup_busy_reg) begin
      if (setup_div_reg != 8'(UNIT_CYCLES - 1)) begin
        setup_div_reg <= setup_div_reg + 8'h01;
      end else begin
        // a zero width still gives one unit, as on the master side
        setup_div_reg <= 8'h00;
        if (setup_cnt_reg + 8'h01 >= low_width_reg) begin
          setup_busy_reg    <= 1'b0;
          slave_scl_release <= 1'b1;
        end else begin
          setup_cnt_reg <= setup_cnt_reg + 8'h01;
        end
      end
    end
  end

  // interrupt events; set wins over write-one-to-clear
  assign irq_events[IRQ_ERROR_BIT] = run_en && selftest_error;
  assign irq_events[IRQ_WRAP_BIT]  = run_en && selftest_error && errors_reg == 8'hFE;
  assign irq_events[IRQ_SCL_BIT]   = slave_scl_release;

  // sticky status, write one to clear; a clear never hides an event of the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
    end else if (wr_fire && w_strb_reg[0] && aw_idx_reg == IDX_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~w_data_reg[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  // level interrupt, one cycle behind the status so the pin comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // read path
  assign rd_idx = s_axi_araddr[9:2];
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (rd_idx)
      IDX_SELFTEST_CONTROL: rd_byte = {ctrl_rsvd_reg, ctrl_reg};
      IDX_SELFTEST_ERRORS:  rd_byte = errors_reg;
      IDX_CLOCK_HIGH_WIDTH: rd_byte = high_width_reg;
      IDX_CLOCK_LOW_WIDTH:  rd_byte = low_width_reg;
      IDX_IRQ_STATUS:       rd_byte = {5'h00, irq_status_reg};
      IDX_IRQ_MASK:         rd_byte = {5'h00, irq_mask_reg};
      default:              rd_hit  = 1'b0;
    endcase
  end

  // read channel: one read at a time, data latched when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== selftest_regs_sva.sv
`default_nettype none
module selftest_regs_sva
  import selftest_pkg::*;
(
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          selftest_active,
  input wire logic [1:0]    receive_osc_freq_select,
  input wire logic          osc_freq_valid,
  input wire remote_write_t remote_write,
  input wire logic          scl_oe,
  input wire logic          slave_scl_release
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_cnt;
  logic        oe_prev;
  logic        seen_edge;

  // phase length of scl_oe; the first phase after reset is skipped, it has no clean start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_cnt   <= 16'h0001;
      oe_prev   <= 1'b0;
      seen_edge <= 1'b0;
    end else begin
      oe_prev <= scl_oe;
      if (scl_oe != oe_prev) begin
        run_cnt   <= 16'h0001;
        seen_edge <= 1'b1;
      end else begin
        run_cnt <= run_cnt + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence start_s;
    $rose(selftest_active);
  endsequence
  sequence pulse_s;
    remote_write.valid ##1 !remote_write.valid;
  endsequence

  start_pulse_a: assert property (start_s |-> pulse_s)
    else $error("no single remote write at self-test start");
  write_cause_a: assert property (remote_write.valid |-> start_s)
    else $error("remote write without self-test start");
  remote_offset_a: assert property (remote_write.valid |->
    remote_write.offset == REMOTE_CLOCK_SRC_OFFSET)
    else $error("remote write offset wrong");
  freq_valid_a: assert property (osc_freq_valid |-> receive_osc_freq_select != 2'h3)
    else $error("reserved frequency code flagged valid");
  scl_phase_a: assert property ((seen_edge && scl_oe != oe_prev) |->
    (run_cnt >= UNIT_CYCLES && run_cnt % UNIT_CYCLES == 0))
    else $error("scl phase not a whole number of units");
  release_pulse_a: assert property (slave_scl_release |=> !slave_scl_release)
    else $error("slave release longer than one cycle");
  bresp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  rresp_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
endmodule

bind selftest_regs selftest_regs_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .selftest_active(selftest_active),
  .receive_osc_freq_select(receive_osc_freq_select), .osc_freq_valid(osc_freq_valid),
  .remote_write(remote_write), .scl_oe(scl_oe), .slave_scl_release(slave_scl_release));
`default_nettype wire

// ===== selftest_regs_bench.sv
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %0h vs %0h", $time, (g), (e)); end end
module selftest_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import selftest_pkg::*;
  localparam logic [31:0] CTL = {22'h0, IDX_SELFTEST_CONTROL, 2'b00};
  localparam logic [31:0] ERR = {22'h0, IDX_SELFTEST_ERRORS, 2'b00};
  localparam logic [31:0] HI  = {22'h0, IDX_CLOCK_HIGH_WIDTH, 2'b00};
  localparam logic [31:0] LO  = {22'h0, IDX_CLOCK_LOW_WIDTH, 2'b00};
  localparam logic [31:0] STS = {22'h0, IDX_IRQ_STATUS, 2'b00};
  localparam logic [31:0] MSK = {22'h0, IDX_IRQ_MASK, 2'b00};
  logic          aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready, auto_en, pin_en, st_err, setup;
  logic          active, int_sel, fvalid, scl_o, scl_oe, rel, irq;
  logic [31:0]   awaddr, wdata, araddr, rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, pin_csrc, fsel, rem_data;
  remote_write_t rw;
  int            rem_cnt, fails, check_count, n, m;

  selftest_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .auto_clock_en(auto_en), .selftest_pin_en(pin_en), .selftest_pin_csrc(pin_csrc),
    .selftest_error(st_err), .slave_setup_start(setup), .selftest_active(active),
    .internal_pclk_sel(int_sel), .receive_osc_freq_select(fsel), .osc_freq_valid(fvalid),
    .remote_write(rw), .scl_out(scl_o), .scl_oe(scl_oe), .slave_scl_release(rel), .irq(irq));

  always #5 aclk = ~aclk;

  // remote writes are one-cycle pulses, so they are caught here rather than polled
  always @(posedge aclk) begin
    if (rw.valid === 1'b1) begin
      rem_cnt  <= rem_cnt + 1;
      rem_data <= rw.data;
    end
  end

  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // response code 3 means any answer is accepted
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
    int t;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 200);
    bready <= 1'b0;
    if (t == 200) fails++;
    if (er != 2'h3) `CHK(bresp, er)
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] er);
    int t;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 200);
    rready <= 1'b0;
    if (t == 200) fails++;
    `CHK(rresp, er)
    if (er == RESP_OKAY) `CHK(rdata, {24'h000000, e})
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic errs(input int k);
    repeat (k) begin
      @(posedge aclk);
      st_err <= 1'b1;
      @(posedge aclk);
      st_err <= 1'b0;
    end
  endtask

  // skips the phase under way, which may still run on the old width
  task automatic phase(input logic lvl, output int len);
    int t;
    t = 0;
    while (scl_oe === lvl && t < 5000) begin @(posedge aclk); t++; end
    while (scl_oe !== lvl && t < 5000) begin @(posedge aclk); t++; end
    len = 0;
    while (scl_oe === lvl && t < 5000) begin @(posedge aclk); len++; t++; end
  endtask

  // hang guard, dozens of times the expected run length
  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    report_and_stop();
  end

  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = '0; wdata = '0; araddr = '0; wstrb = '0;
    auto_en = 1'b0; pin_en = 1'b0; pin_csrc = 2'h0; st_err = 1'b0; setup = 1'b0;
    rem_cnt = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTL, RST_SELFTEST_CONTROL, RESP_OKAY);
    rd(ERR, 8'h00, RESP_OKAY);
    rd(HI, 8'h83, RESP_OKAY);
    rd(LO, 8'h84, RESP_OKAY);
    rd(32'h000000A0, 8'h00, RESP_SLVERR);
    wr(32'h000000A0, 32'h000000FF, 4'hF, RESP_SLVERR);
    wr(HI, 32'h00000011, 4'h0, RESP_OKAY);
    rd(HI, 8'h83, RESP_OKAY);
    auto_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(CTL, {26'h0, 2'(c), 4'h0}, 4'hF, RESP_OKAY);
      cyc(2);
      `CHK(fsel, 2'(c))
      `CHK(fvalid, c != 3)
    end
    auto_en <= 1'b0;
    cyc(2);
    `CHK(fvalid, 1'b0)
    // every clock source code, each start must send exactly one remote write
    for (int c = 0; c < 4; c++) begin
      m = rem_cnt;
      wr(CTL, {29'h0, 2'(c), 1'b1}, 4'hF, RESP_OKAY);
      cyc(2);
      `CHK(active, 1'b1)
      `CHK(int_sel, c != 0)
      `CHK(rem_data, 2'(c))
      `CHK(rem_cnt, m + 1)
      wr(CTL, 32'h00000000, 4'hF, RESP_OKAY);
      cyc(2);
      `CHK(active, 1'b0)
    end
    wr(CTL, 32'h00000001, 4'hF, RESP_OKAY);
    errs(3);
    wr(CTL, 32'h00000000, 4'hF, RESP_OKAY);
    errs(2);
    wr(ERR, 32'h00000055, 4'hF, 2'h3);
    rd(ERR, 8'h03, RESP_OKAY);
    // pin decides; the register enable bit alone must not start anything
    wr(CTL, 32'h00000009, 4'hF, RESP_OKAY);
    cyc(2);
    `CHK(active, 1'b0)
    m = rem_cnt;
    pin_csrc <= 2'h2;
    pin_en <= 1'b1;
    cyc(3);
    `CHK(active, 1'b1)
    `CHK(rem_data, 2'h2)
    `CHK(rem_cnt, m + 1)
    rd(ERR, 8'h00, RESP_OKAY);
    pin_en <= 1'b0;
    cyc(3);
    `CHK(active, 1'b0)
    // a zero width still lasts one unit
    wr(HI, 32'h00000000, 4'hF, RESP_OKAY);
    wr(LO, 32'h00000003, 4'hF, RESP_OKAY);
    phase(1'b0, n);
    `CHK(n, UNIT_CYCLES)
    phase(1'b1, n);
    `CHK(n, 3 * UNIT_CYCLES)
    @(posedge aclk) setup <= 1'b1;
    @(posedge aclk) setup <= 1'b0;
    n = 0;
    while (rel !== 1'b1 && n < 100) begin @(posedge aclk); n++; end
    `CHK(n, 3 * UNIT_CYCLES + 1)
    rd(STS, 8'h05, RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(MSK, 32'h00000001, 4'hF, RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(STS, 32'h00000001, 4'hF, RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b0)
    rd(STS, 8'h04, RESP_OKAY);
    wr(MSK, 32'h00000004, 4'hF, RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(STS, 32'h00000004, 4'hF, RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b0)
    // run the tally into its ceiling: it must stop there and flag the wrap once
    wr(CTL, 32'h00000001, 4'hF, RESP_OKAY);
    errs(256);
    rd(ERR, 8'hFF, RESP_OKAY);
    rd(STS, 8'h03, RESP_OKAY);
    wr(MSK, 32'h00000002, 4'hF, RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b1)
    report_and_stop();
  end
endmodule
`default_nettype wire
